// [core/emd_pkg.sv]
package emd_pkg;
  // Observed bus widths and channel counts
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 12;
  localparam int NUM_EV = 8;
  localparam int NUM_PROBE = 4;
  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [9:0] CTRL_OFS = 10'h000;
  localparam logic [9:0] STAT_OFS = 10'h004;
  localparam logic [9:0] MASK_OFS = 10'h008;
  localparam logic [9:0] ROMBP_OFS = 10'h00C;
  localparam logic [9:0] BPIDX_OFS = 10'h010;
  localparam logic [9:0] BPDAT_OFS = 10'h014;
  localparam logic [9:0] ACC_OFS = 10'h018;
  localparam logic [9:0] CH_BASE = 10'h100;
  localparam logic [9:0] CH_END = 10'h280;

  // Word slots inside one channel block of eight words
  localparam logic [2:0] CH_LO = 3'h0;
  localparam logic [2:0] CH_HI = 3'h1;
  localparam logic [2:0] CH_DAT = 3'h2;
  localparam logic [2:0] CH_MSK = 3'h3;
  localparam logic [2:0] CH_CND = 3'h4;
  localparam logic [2:0] CH_CNT = 3'h5;
  localparam logic [2:0] CH_DLY = 3'h6;
  localparam logic [2:0] CH_ACT = 3'h7;

  // Condition word fields
  localparam int AM_LSB = 0;
  localparam int DIR_LSB = 2;
  localparam int DEN_BIT = 4;
  localparam int BS_LSB = 5;
  localparam int AR_LSB = 11;
  localparam int PV_LSB = 18;
  localparam int PC_LSB = 22;
  localparam int CEN_BIT = 31;
  localparam logic [1:0] AM_ANY = 2'h0;
  localparam logic [1:0] AM_SINGLE = 2'h1;
  localparam logic [1:0] AM_RANGE = 2'h2;
  localparam logic [1:0] DIR_RD = 2'h1;
  localparam logic [1:0] DIR_WR = 2'h2;

  // Control word fields, action bits, status bits
  localparam int SEQ_EN_BIT = 0;
  localparam int SEQ_LEN_LSB = 1;
  localparam int SUP_LSB = 4;
  localparam int ACC_LSB = 10;
  localparam int ROM_EN_BIT = 31;
  localparam int BP_ARM_BIT = 31;
  localparam int ACT_HALT = 0;
  localparam int ACT_TSTART = 1;
  localparam int ACT_TSTOP = 2;
  localparam int ACT_MSTART = 3;
  localparam int ACT_MSTOP = 4;
  localparam int ST_PC = 12;
  localparam int ST_ROM = 13;
  localparam int ST_SEQ = 14;
  localparam int STAT_W = 15;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  typedef enum logic [2:0] {prefetch_cycle_tag, data_cycle_tag,
    refresh_cycle_tag, dma_cycle_tag, transfer_ctrl_cycle_tag,
    other_cycle_tag} emd_state_t;
  typedef enum logic [2:0] {rom_area, ram_area, io_wide_area,
    io_narrow_area, external_io_wide_area, external_io_narrow_area,
    transfer_ctrl_ram_area} emd_area_t;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic write;
    logic done;
    emd_state_t state;
    emd_area_t area;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } emd_bus_t;

  typedef struct packed {
    emd_state_t state;
    emd_area_t area;
  } emd_tag_t;
endpackage

// [core/emd_top.sv]
// Summary of operation
// - A fetch from an armed table address halts the program; 256 entries.
// - Only one breakpoint may sit in ROM; table entries never hit in ROM.
// - The ROM breakpoint halts after its instruction completes, not at fetch.
// - At most twelve event points exist across both channel kinds.
// - Channels 1 to 8 are event channels and 9 to 12 are range channels.
// - Match address, in or out of range, direction, data, bus, area, probes.
// - An event channel counts occurrences and reports only at the set count.
// - Every channel can delay its report by a set number of cycles.
// - Range channels match like event channels but never count or sequence.
// - Up to eight event channels chain so each stage arms after the last.
// - A reported point can halt, or start or stop trace and time measure.
// - Detection is pipelined, so actions follow conditions by a few cycles.
// - Each cycle is tagged prefetch, data, refresh, dma, transfer or other.
// - Each access is tagged with one of seven memory areas.
// - Bus tags also suppress trace capture and select counted accesses.
// - Each captured cycle carries its bus and area tags.
`timescale 1ns/1ns
`default_nettype none
module emd_top #(
  parameter int NUM_BP = 256
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Observed bus and probe pins
  input wire emd_pkg::emd_bus_t mcu_bus,
  input wire logic [emd_pkg::NUM_PROBE-1:0] probe_pins,
  // Actions
  output logic halt_req,
  output logic trace_on,
  output logic meas_on,
  output logic trace_capture,
  output emd_pkg::emd_tag_t trace_tag,
  output logic irq
);
  localparam int BPI_W = $clog2(NUM_BP);

  // Channel match on one sampled cycle
  function automatic logic chan_match(input logic [31:0] lo, hi, dat, msk,
    cnd, input emd_pkg::emd_bus_t b, input logic [3:0] pr);
    logic in_rng;
    logic am_ok;
    logic dir_ok;
    logic dat_ok;
    logic [1:0] dir;
    in_rng = (b.addr >= lo[23:0]) && (b.addr <= hi[23:0]);
    case (cnd[emd_pkg::AM_LSB +: 2])
      emd_pkg::AM_ANY: am_ok = 1'b1;
      emd_pkg::AM_SINGLE: am_ok = (b.addr == lo[23:0]);
      emd_pkg::AM_RANGE: am_ok = in_rng;
      default: am_ok = !in_rng;
    endcase
    dir = cnd[emd_pkg::DIR_LSB +: 2];
    dir_ok = !((dir == emd_pkg::DIR_RD && b.write) ||
      (dir == emd_pkg::DIR_WR && !b.write));
    // Masked-out bits always match
    dat_ok = !cnd[emd_pkg::DEN_BIT] ||
      (((b.data ^ dat[15:0]) & msk[15:0]) == 16'h0000);
    return cnd[emd_pkg::CEN_BIT] && b.valid && am_ok && dir_ok && dat_ok &&
      cnd[emd_pkg::BS_LSB + b.state] && cnd[emd_pkg::AR_LSB + b.area] &&
      (((pr ^ cnd[emd_pkg::PV_LSB +: 4]) & cnd[emd_pkg::PC_LSB +: 4]) ==
      4'h0);
  endfunction

  logic [31:0] ctrl;
  logic [31:0] rom_bp;
  logic [emd_pkg::STAT_W-1:0] status;
  logic [emd_pkg::STAT_W-1:0] mask;
  logic [31:0] acc_cnt;
  logic [BPI_W-1:0] bp_idx;
  logic [emd_pkg::ADDR_W-1:0] bp_addr [NUM_BP];
  logic [NUM_BP-1:0] bp_arm;
  logic [31:0] cfg [emd_pkg::NUM_CH][8];
  logic [3:0] probe_m;
  logic [3:0] probe_s;
  emd_pkg::emd_bus_t bus_q;
  logic [emd_pkg::NUM_CH-1:0] hit_q;
  logic [2:0] seq_stage;
  logic rom_pend;

  // Bus slave decode; one wait state on every access
  wire [9:0] byte_addr = {avs_address, 2'b00};
  wire wr_go = avs_write && !avs_waitrequest;
  wire in_ch = byte_addr >= emd_pkg::CH_BASE && byte_addr < emd_pkg::CH_END;
  wire [9:0] ch_off = byte_addr - emd_pkg::CH_BASE;
  wire [3:0] ch_idx = ch_off[8:5];
  wire [2:0] ch_slot = ch_off[4:2];
  wire wr_ctrl = wr_go && byte_addr == emd_pkg::CTRL_OFS;
  wire wr_stat = wr_go && byte_addr == emd_pkg::STAT_OFS;
  wire wr_mask = wr_go && byte_addr == emd_pkg::MASK_OFS;
  wire wr_rom = wr_go && byte_addr == emd_pkg::ROMBP_OFS;
  wire wr_bpi = wr_go && byte_addr == emd_pkg::BPIDX_OFS;
  wire wr_bpd = wr_go && byte_addr == emd_pkg::BPDAT_OFS;
  wire wr_acc = wr_go && byte_addr == emd_pkg::ACC_OFS;
  wire wr_ch = wr_go && in_ch;
  wire [31:0] bp_rd = {bp_arm[bp_idx], 7'h00, bp_addr[bp_idx]};
  // Unmapped addresses read as zero
  wire [31:0] rd_mux =
    byte_addr == emd_pkg::CTRL_OFS ? ctrl :
    byte_addr == emd_pkg::STAT_OFS ? 32'(status) :
    byte_addr == emd_pkg::MASK_OFS ? 32'(mask) :
    byte_addr == emd_pkg::ROMBP_OFS ? rom_bp :
    byte_addr == emd_pkg::BPIDX_OFS ? 32'(bp_idx) :
    byte_addr == emd_pkg::BPDAT_OFS ? bp_rd :
    byte_addr == emd_pkg::ACC_OFS ? acc_cnt :
    in_ch ? cfg[ch_idx][ch_slot] : 32'h0000_0000;

  // Waitrequest drops for the single accepting cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // Software registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= emd_pkg::CFG_RST;
      rom_bp <= emd_pkg::CFG_RST;
      mask <= '0;
      bp_idx <= '0;
      bp_arm <= '0;
      for (int c = 0; c < emd_pkg::NUM_CH; c++) begin
        for (int s = 0; s < 8; s++) begin
          cfg[c][s] <= emd_pkg::CFG_RST;
        end
      end
    end else begin
      if (wr_ctrl) ctrl <= avs_writedata;
      if (wr_rom) rom_bp <= avs_writedata;
      if (wr_mask) mask <= avs_writedata[emd_pkg::STAT_W-1:0];
      if (wr_bpi) bp_idx <= avs_writedata[BPI_W-1:0];
      if (wr_bpd) bp_arm[bp_idx] <= avs_writedata[emd_pkg::BP_ARM_BIT];
      if (wr_ch) cfg[ch_idx][ch_slot] <= avs_writedata;
    end
  end

  // Table addresses are memory; only the arm bits need reset
  always_ff @(posedge ref_clk) begin
    if (wr_bpd) bp_addr[bp_idx] <= avs_writedata[emd_pkg::ADDR_W-1:0];
  end

  // Probe pins are asynchronous to the bus clock
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      probe_m <= 4'h0;
      probe_s <= 4'h0;
      bus_q <= '0;
    end else begin
      probe_m <= probe_pins;
      probe_s <= probe_m;
      bus_q <= mcu_bus;
    end
  end

  // Program-counter table compare, one comparator per entry
  wire [NUM_BP-1:0] bp_match;
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BP; gb++) begin : bpt
      assign bp_match[gb] = bp_arm[gb] && bp_addr[gb] == bus_q.addr;
    end
  endgenerate
  wire fetch_q = bus_q.valid && bus_q.fetch;
  wire in_rom = bus_q.area == emd_pkg::rom_area;
  wire pc_hit = fetch_q && !in_rom && |bp_match;
  wire rom_hit = fetch_q && in_rom && rom_bp[emd_pkg::ROM_EN_BIT] &&
    bus_q.addr == rom_bp[emd_pkg::ADDR_W-1:0];
  wire rom_done = rom_pend && bus_q.done;

  // ROM breakpoint waits for its instruction to complete
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rom_pend <= 1'b0;
    end else begin
      rom_pend <= rom_hit || (rom_pend && !bus_q.done);
    end
  end

  // Channel compare, counting, sequencing and delay
  wire [emd_pkg::NUM_CH-1:0] raw;
  wire [emd_pkg::NUM_CH-1:0] occ;
  wire [emd_pkg::NUM_CH-1:0] fire;
  wire seq_en = ctrl[emd_pkg::SEQ_EN_BIT];
  wire [2:0] seq_last = ctrl[emd_pkg::SEQ_LEN_LSB +: 3];
  genvar gc;
  generate
    for (gc = 0; gc < emd_pkg::NUM_CH; gc++) begin : chn
      logic pend;
      logic f;
      logic [emd_pkg::CNT_W-1:0] dly_left;
      wire [emd_pkg::CNT_W-1:0] dly = cfg[gc][emd_pkg::CH_DLY][15:0];
      assign raw[gc] = chan_match(cfg[gc][emd_pkg::CH_LO],
        cfg[gc][emd_pkg::CH_HI], cfg[gc][emd_pkg::CH_DAT],
        cfg[gc][emd_pkg::CH_MSK], cfg[gc][emd_pkg::CH_CND], bus_q,
        probe_s);
      if (gc < emd_pkg::NUM_EV) begin : ev
        logic [emd_pkg::CNT_W-1:0] left;
        wire [emd_pkg::CNT_W-1:0] goal = cfg[gc][emd_pkg::CH_CNT][15:0];
        // Stage gating: outside the chain a channel is always armed
        wire armed = !seq_en || 3'(gc) > seq_last || seq_stage == 3'(gc);
        wire reached = left <= 16'h0001;
        wire go = hit_q[gc] && armed;
        assign occ[gc] = go && reached;
        // Zero and one both mean report on first occurrence
        always_ff @(posedge ref_clk or negedge nrst) begin
          if (!nrst) begin
            left <= 16'h0000;
          end else if (!cfg[gc][emd_pkg::CH_CND][emd_pkg::CEN_BIT]) begin
            left <= goal;
          end else if (go) begin
            left <= reached ? goal : left - 16'h0001;
          end
        end
      end else begin : rg
        assign occ[gc] = hit_q[gc];
      end
      // Occurrences during a running delay are dropped
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          pend <= 1'b0;
          f <= 1'b0;
          dly_left <= 16'h0000;
        end else begin
          f <= (occ[gc] && !pend && dly == 16'h0000) ||
            (pend && dly_left == 16'h0001);
          if (pend) begin
            dly_left <= dly_left - 16'h0001;
            pend <= dly_left != 16'h0001;
          end else if (occ[gc] && dly != 16'h0000) begin
            dly_left <= dly;
            pend <= 1'b1;
          end
        end
      end
      assign fire[gc] = f;
    end
  endgenerate

  // Sequence pointer advances on the armed stage only
  wire seq_adv = seq_en && occ[seq_stage];
  wire seq_fin = seq_adv && seq_stage == seq_last;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seq_stage <= 3'h0;
      hit_q <= '0;
    end else begin
      hit_q <= raw;
      if (!seq_en || seq_fin) begin
        seq_stage <= 3'h0;
      end else if (seq_adv) begin
        seq_stage <= seq_stage + 3'h1;
      end
    end
  end

  // Gather the actions of reporting channels
  logic [4:0] act;
  always_comb begin
    act = 5'h00;
    for (int c = 0; c < emd_pkg::NUM_CH; c++) begin
      if (fire[c]) act = act | cfg[c][emd_pkg::CH_ACT][4:0];
    end
  end

  wire sup_hit = ctrl[emd_pkg::SUP_LSB + bus_q.state];
  wire acc_hit = ctrl[emd_pkg::ACC_LSB + bus_q.state];
  wire [emd_pkg::STAT_W-1:0] ev_set = {seq_fin, rom_done, pc_hit, fire};
  wire [emd_pkg::STAT_W-1:0] next_status = (status &
    ~(wr_stat ? avs_writedata[emd_pkg::STAT_W-1:0] : '0)) | ev_set;
  wire [emd_pkg::STAT_W-1:0] next_mask =
    wr_mask ? avs_writedata[emd_pkg::STAT_W-1:0] : mask;

  // Actions and trace; stop beats start in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      halt_req <= 1'b0;
      trace_on <= 1'b0;
      meas_on <= 1'b0;
      trace_capture <= 1'b0;
      trace_tag <= '0;
      acc_cnt <= 32'h0000_0000;
    end else begin
      halt_req <= pc_hit || rom_done || act[emd_pkg::ACT_HALT];
      trace_on <= !act[emd_pkg::ACT_TSTOP] &&
        (trace_on || act[emd_pkg::ACT_TSTART]);
      meas_on <= !act[emd_pkg::ACT_MSTOP] &&
        (meas_on || act[emd_pkg::ACT_MSTART]);
      trace_capture <= trace_on && bus_q.valid && !sup_hit;
      trace_tag <= {bus_q.state, bus_q.area};
      if (wr_acc) begin
        acc_cnt <= 32'h0000_0000;
      end else if (meas_on && bus_q.valid && acc_hit) begin
        acc_cnt <= acc_cnt + 32'h0000_0001;
      end
    end
  end

  // Sticky status, set wins over a same-cycle clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      irq <= |(next_status & next_mask);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence rom_arm_s;
    rom_hit && !bus_q.done;
  endsequence
  sequence rom_end_s;
    rom_pend && bus_q.done;
  endsequence

  pc_halt_a: assert property (pc_hit |=> halt_req)
    else $error("table hit did not halt");
  rom_table_a: assert property (fetch_q && in_rom |=>
    !$rose(status[emd_pkg::ST_PC]))
    else $error("table hit inside rom");
  rom_wait_a: assert property (rom_arm_s |=> rom_pend)
    else $error("rom stop not pending");
  rom_after_a: assert property (rom_end_s |=>
    halt_req && status[emd_pkg::ST_ROM])
    else $error("rom stop not after completion");
  count_gate_a: assert property (chn[1].ev.go &&
    !chn[1].ev.reached && cfg[1][emd_pkg::CH_CND][emd_pkg::CEN_BIT] |=>
    chn[1].ev.left == $past(chn[1].ev.left) - 16'h0001)
    else $error("count did not step");
  delay_count_a: assert property (occ[8] && !chn[8].pend &&
    cfg[8][emd_pkg::CH_DLY][15:0] == 16'h0003 |=> !fire[8] [*3] ##1 fire[8])
    else $error("delayed report off time");
  seq_step_a: assert property (seq_adv && !seq_fin |=>
    seq_stage == $past(seq_stage) + 3'h1)
    else $error("sequence did not advance");
  seq_arm_a: assert property (seq_en && seq_last != 3'h0 &&
    seq_stage == 3'h0 |-> !occ[1])
    else $error("later stage fired early");
  halt_act_a: assert property (fire[0] &&
    cfg[0][emd_pkg::CH_ACT][emd_pkg::ACT_HALT] |=> halt_req)
    else $error("halt action lost");
  trace_sup_a: assert property (trace_capture |-> !$past(sup_hit))
    else $error("suppressed cycle captured");
  trace_tag_a: assert property (trace_capture |->
    trace_tag == $past({bus_q.state, bus_q.area}))
    else $error("trace tag mismatch");
  irq_level_a: assert property ((status & mask) != '0 |-> irq)
    else $error("interrupt not raised");
endmodule
`default_nettype wire

// [tb/emd_mcu_model.sv]
`timescale 1ns/1ns
`default_nettype none
module emd_mcu_model (
  // Clock
  input wire logic ref_clk,
  // Observed bus
  output var emd_pkg::emd_bus_t mcu_bus
);
  initial mcu_bus = '0;

  // One bus cycle, then released with inverted lines so stale values never match
  task automatic cyc(input logic f, w, d, input logic [2:0] s, ar,
                     input logic [23:0] a, input logic [15:0] dt);
    @(posedge ref_clk);
    mcu_bus <= {1'b1, f, w, d, s, ar, a, dt};
    @(posedge ref_clk);
    mcu_bus <= {4'h0, ~s, ~ar, ~a, ~dt};
  endtask
endmodule
`default_nettype wire

// [tb/test_emulator_event_detection.sv]
`timescale 1ns/1ns
`default_nettype none
module test_emulator_event_detection;
  localparam logic [7:0] CT = emd_pkg::CTRL_OFS[9:2];
  localparam logic [7:0] ST = emd_pkg::STAT_OFS[9:2];
  localparam logic [7:0] MK = emd_pkg::MASK_OFS[9:2];
  localparam logic [7:0] RB = emd_pkg::ROMBP_OFS[9:2];
  localparam logic [7:0] BI = emd_pkg::BPIDX_OFS[9:2];
  localparam logic [7:0] BD = emd_pkg::BPDAT_OFS[9:2];
  localparam logic [7:0] AC = emd_pkg::ACC_OFS[9:2];
  logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic halt_req, trace_on, meas_on, trace_capture, irq, ton_q, mon_q;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] probe_pins;
  emd_pkg::emd_bus_t mcu_bus;
  emd_pkg::emd_tag_t trace_tag, last_tag;
  int bad_count, total_checks, cyc, stamp, halt_n, halt_at, cap_n, ton_at;
  int mon_at, c0;

  emd_top #(.NUM_BP(8)) dut (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mcu_bus(mcu_bus),
    .probe_pins(probe_pins), .halt_req(halt_req), .trace_on(trace_on),
    .meas_on(meas_on), .trace_capture(trace_capture),
    .trace_tag(trace_tag), .irq(irq));
  emd_mcu_model mcu (.ref_clk(ref_clk), .mcu_bus(mcu_bus));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Action stamps, taken mid-cycle where outputs are settled
  always @(negedge ref_clk) begin
    cyc++;
    if (halt_req === 1'b1) begin
      halt_n++;
      halt_at = cyc;
    end
    if (trace_capture === 1'b1) begin
      cap_n++;
      last_tag = trace_tag;
    end
    if (trace_on !== ton_q) ton_at = cyc;
    if (meas_on !== mon_q) mon_at = cyc;
    ton_q = trace_on;
    mon_q = meas_on;
  end

  task automatic chk(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Avalon access; holds everything until waitrequest is seen low
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "bus answer");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string s);
    xfer(1'b0, a, 32'h0);
    chk(rd, e, s);
  endtask

  function automatic logic [7:0] cw(input int ch, input int k);
    return emd_pkg::CH_BASE[9:2] + 8'(ch * 8 + k);
  endfunction

  function automatic logic [31:0] cond(input logic [1:0] am, dir,
      input logic de, input logic [5:0] st, input logic [6:0] ar);
    return 32'h8000_0000 | 32'(am) | (32'(dir) << emd_pkg::DIR_LSB)
      | (32'(de) << emd_pkg::DEN_BIT) | (32'(st) << emd_pkg::BS_LSB)
      | (32'(ar) << emd_pkg::AR_LSB);
  endfunction

  task automatic chan(input int ch, input logic [31:0] lo, hi, dat, msk, cnd,
                      cnt, dly, act);
    logic [31:0] v [8];
    v = '{lo, hi, dat, msk, cnd, cnt, dly, act};
    // Condition word last, so the count loads while the channel is off
    for (int i = 5; i < 13; i++) wr(cw(ch, i % 8), v[i % 8]);
  endtask

  // One bus cycle, then a halt count and latency in edges (lat < 0: none)
  task automatic bh(input logic f, w, d, input int s, ar, input logic [23:0] a,
                    input logic [15:0] dt, input int lat, input string what);
    int h0;
    h0 = halt_n;
    mcu.cyc(f, w, d, s[2:0], ar[2:0], a, dt);
    stamp = cyc;
    repeat (8) @(negedge ref_clk);
    chk(halt_n - h0, (lat < 0) ? 0 : 1, what);
    if (lat >= 0) chk(halt_at - stamp, lat, what);
  endtask

  // Hang guard, far beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  // Tests
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    probe_pins = 4'h0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rdchk(CT, 32'h0, "ctrl reset");
    rdchk(ST, 32'h0, "status reset");
    rdchk(MK, 32'h0, "mask reset");
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'h0, "unmapped");
    wr(cw(12, 0), 32'h0000_1234);
    rdchk(cw(12, 0), 32'h0, "no channel 13");
    $display("test reset done");
    // Breakpoint table, last entry, irq raise, clear and mask
    wr(BI, 32'h7);
    wr(BD, 32'h8000_1234);
    rdchk(BD, 32'h8000_1234, "bp entry");
    wr(MK, 32'h1000);
    bh(1'b1, 1'b0, 1'b0, 0, 1, 24'h1234, 16'h0, 2, "pc hit");
    rdchk(ST, 32'h1000, "pc status");
    chk(irq, 1'b1, "irq on");
    wr(ST, 32'h1000);
    rdchk(ST, 32'h0, "w1c");
    chk(irq, 1'b0, "irq off");
    wr(MK, 32'h0);
    bh(1'b1, 1'b0, 1'b0, 0, 1, 24'h1234, 16'h0, 2, "pc hit 2");
    chk(irq, 1'b0, "irq masked");
    wr(ST, 32'h1000);
    bh(1'b1, 1'b0, 1'b0, 0, 0, 24'h1234, 16'h0, -1, "rom table");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h1234, 16'h0, -1, "data");
    bh(1'b1, 1'b0, 1'b0, 0, 1, 24'h1236, 16'h0, -1, "other pc");
    $display("test pc done");
    // ROM breakpoint stops after completion
    wr(RB, 32'h8000_0200);
    bh(1'b1, 1'b0, 1'b0, 0, 0, 24'h200, 16'h0, -1, "rom fetch");
    bh(1'b0, 1'b0, 1'b1, 5, 1, 24'h0, 16'h0, 2, "rom done");
    rdchk(ST, 32'h2000, "rom status");
    wr(RB, 32'h0);
    $display("test rom done");
    // Event channel: single address, write, masked data
    chan(0, 32'h4000, 32'h0, 32'h12A5, 32'hFF00,
         cond(2'h1, 2'h2, 1'b1, 6'h02, 7'h02), 32'h0, 32'h0, 32'h1);
    bh(1'b0, 1'b1, 1'b0, 1, 1, 24'h4000, 16'h12FF, 4, "mask hit");
    bh(1'b0, 1'b1, 1'b0, 1, 1, 24'h4000, 16'h13A5, -1, "data miss");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h4000, 16'h12A5, -1, "dir miss");
    bh(1'b0, 1'b1, 1'b0, 1, 1, 24'h4001, 16'h12A5, -1, "addr miss");
    bh(1'b0, 1'b1, 1'b0, 1, 2, 24'h4000, 16'h12A5, -1, "area miss");
    wr(cw(0, 4), cond(2'h1, 2'h2, 1'b1, 6'h02, 7'h02) | 32'h0044_0000);
    bh(1'b0, 1'b1, 1'b0, 1, 1, 24'h4000, 16'h12A5, -1, "probe miss");
    @(posedge ref_clk);
    probe_pins <= 4'h1;
    bh(1'b0, 1'b1, 1'b0, 1, 1, 24'h4000, 16'h12A5, 4, "probe hit");
    wr(cw(0, 1), 32'h40FF);
    wr(cw(0, 4), cond(2'h3, 2'h0, 1'b0, 6'h3F, 7'h7F));
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h4010, 16'h0, -1, "inside");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h5000, 16'h0, 4, "outside");
    // Every bus state and every area
    for (int i = 0; i < 7; i++) begin
      wr(cw(0, 4), cond(2'h0, 2'h0, 1'b0, 6'(1 << (i % 6)), 7'(1 << i)));
      bh(1'b0, 1'b0, 1'b0, i % 6, i, 24'h10, 16'h0, 4, "tag hit");
      bh(1'b0, 1'b0, 1'b0, (i + 1) % 6, i, 24'h10, 16'h0, -1, "st");
      bh(1'b0, 1'b0, 1'b0, i % 6, (i + 1) % 7, 24'h10, 16'h0, -1, "ar");
    end
    wr(cw(0, 4), 32'h0);
    $display("test match done");
    // Occurrence count of three
    chan(1, 32'h5000, 32'h0, 32'h0, 32'h0, cond(2'h1, 2'h0, 1'b0, 6'h3F, 7'h7F),
         32'h3, 32'h0, 32'h1);
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h5000, 16'h0, -1, "count 1");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h5000, 16'h0, -1, "count 2");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h5000, 16'h0, 4, "count 3");
    wr(cw(1, 4), 32'h0);
    $display("test count done");
    // Range channels: delayed trace start, stops, meas with count ignored
    chan(8, 32'h6000, 32'h60FF, 32'h0, 32'h0,
         cond(2'h2, 2'h0, 1'b0, 6'h3F, 7'h7F), 32'h0, 32'h3, 32'h2);
    for (int i = 9; i < 12; i++) begin
      chan(i, 32'h6000 + 32'((i - 8) * 256), 32'h0, 32'h0, 32'h0,
           cond(2'h1, 2'h0, 1'b0, 6'h3F, 7'h7F), 32'h2, 32'h0,
           32'h1 << (i - 7));
    end
    rdchk(cw(11, 0), 32'h6300, "ch12 lo");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h6080, 16'h0, -1, "trace start");
    chk(ton_at - stamp, 32'h7, "trace delay");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h6200, 16'h0, -1, "meas start");
    chk(meas_on, 1'b1, "meas on");
    chk(mon_at - stamp, 32'h4, "meas delay");
    // Trace suppression of refresh, tag recording, access counter
    wr(CT, 32'h0000_0840);
    wr(AC, 32'h0);
    c0 = cap_n;
    bh(1'b0, 1'b0, 1'b0, 1, 3, 24'h7000, 16'h0, -1, "cap data");
    chk(cap_n - c0, 32'h1, "captured");
    chk(last_tag, 32'h0B, "trace tag");
    bh(1'b0, 1'b0, 1'b0, 2, 1, 24'h7000, 16'h0, -1, "cap refresh");
    chk(cap_n - c0, 32'h1, "suppressed");
    rdchk(AC, 32'h1, "access count");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h6100, 16'h0, -1, "trace stop");
    chk(trace_on, 1'b0, "trace off");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h6300, 16'h0, -1, "meas stop");
    chk(meas_on, 1'b0, "meas off");
    $display("test trace done");
    // Two-stage sequence: second stage ignored until the first occurs
    wr(CT, 32'h3);
    chan(0, 32'h7000, 32'h0, 32'h0, 32'h0, cond(2'h1, 2'h0, 1'b0, 6'h3F, 7'h7F),
         32'h0, 32'h0, 32'h0);
    chan(1, 32'h7002, 32'h0, 32'h0, 32'h0, cond(2'h1, 2'h0, 1'b0, 6'h3F, 7'h7F),
         32'h0, 32'h0, 32'h1);
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h7002, 16'h0, -1, "early stage");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h7000, 16'h0, -1, "stage 1");
    bh(1'b0, 1'b0, 1'b0, 1, 1, 24'h7002, 16'h0, 4, "stage 2");
    xfer(1'b0, ST, 32'h0);
    chk(rd[14], 1'b1, "seq status");
    $display("test sequence done");
    print_verdict();
  end
endmodule
`default_nettype wire
